// [design/adc_ctl.sv]
// converter control: overrun policy, dma requests and auto-delayed sequencing
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_ctl_cfg.svh"

// Behaviour
// - conversion done still set: overrun flag set
// - overrun with irq enable raises interrupt
// - overrun never halts; stop request resets sequence
// - overrun flag cleared only by writing one
// - mode zero keeps old result, discards new
// - mode one overwrites result, keeps converting
// - no overrun check on injected conversions
// - each regular completion sets conversion done flag
// - dma enabled: one request per regular conversion
// - overrun blocks dma requests until cleared
// - circular select: zero one-shot, one circular
// - one-shot: no requests after dma end
// - one-shot end freezes, aborts, resets sequence
// - circular: requests continue after dma end
// - auto-delay: regular waits for read/clear
// - auto-delay: injected waits for sequence-done clear
// - delay per regular conversion, per injected sequence
// - delay ignores hardware triggers, not software
// - injected trigger starts during regular delay
// - auto-injection: regular waits for injected delay
// - regular hw trigger ignored, later held pending
// - injected hw trigger ignored while busy/delayed
module adc_ctl (
    // apb clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // hardware trigger pins: bit 0 regular, bit 1 injected
    input  wire logic [1:0]             hw_trig,
    // analog core, same clock
    output adc_ctl_pkg::conv_cmd_t      conv_cmd,
    input  wire adc_ctl_pkg::conv_res_t conv_res,
    // dma controller
    output logic                        dma_req,
    input  wire logic                   dma_ack,
    input  wire logic                   dma_transfer_complete,
    // interrupt
    output logic                        overrun_irq
);
    import adc_ctl_pkg::*;

    ctl_state_t q;
    ctl_state_t n;

    logic       [1:0]  trig_rise;
    logic              dma_frozen;
    logic              dma_stop;
    logic              dma_issue;
    logic              acc;
    logic              wr;
    logic              rd;
    logic              setup;
    logic              hit;
    logic       [31:0] rd_word;
    logic              result_read;
    logic              freeze;
    logic              keep;
    logic              reg_block;
    logic              reg_sw;
    logic              inj_sw;
    logic              reg_stop;
    logic              reg_hw;
    logic              inj_hw;
    logic              cfg_wr;
    logic              inj_start;
    logic              reg_start;

    trig_sync #(
        .W (2)
    ) u_trig_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (hw_trig),
        .rise    (trig_rise)
    );

    dma_req_ctl u_dma_req_ctl (
        .pclk                  (pclk),
        .presetn               (presetn),
        .issue                 (dma_issue),
        .enable                (q.cfg.dma_request_enable),
        .circular              (q.cfg.dma_circular_select),
        .clear                 (cfg_wr),
        .dma_ack               (dma_ack),
        .dma_transfer_complete (dma_transfer_complete),
        .dma_req               (dma_req),
        .frozen                (dma_frozen),
        .stop                  (dma_stop)
    );

    // read mux, built from the current state
    always_comb begin
        rd_word = 32'h0000_0000;
        hit     = 1'b1;
        case (paddr)
            `OFS_STATUS: begin
                rd_word[`STAT_CONV_DONE]  = q.conv_done;
                rd_word[`STAT_OVERRUN]    = q.overrun_flag;
                rd_word[`STAT_INJ_DONE]   = q.injected_sequence_done_flag;
                rd_word[`STAT_REG_BUSY]   = q.st[1] | q.reg_run;
                rd_word[`STAT_INJ_BUSY]   = q.st[2] | q.inj_run;
                rd_word[`STAT_REG_WAIT]   = q.reg_wait;
                rd_word[`STAT_INJ_WAIT]   = q.inj_wait;
                rd_word[`STAT_DMA_FROZEN] = dma_frozen;
            end
            `OFS_IRQ_EN: begin
                rd_word[`IRQEN_OVERRUN] = q.overrun_irq_enable;
            end
            `OFS_CONTROL: begin
                rd_word[`CTRL_REG_START] = q.reg_run;
                rd_word[`CTRL_INJ_START] = q.inj_run;
            end
            `OFS_CONFIG: begin
                rd_word[`CONFIG_W-1:0] = q.cfg;
            end
            `OFS_RESULT: begin
                rd_word[`RESULT_W-1:0] = q.result;
            end
            default: begin
                if (paddr >= `OFS_INJ_RESULT0 && paddr <= `OFS_INJ_RESULT3 && paddr[1:0] == 2'b00) begin
                    rd_word[`RESULT_W-1:0] = q.inj_result[2'(paddr[11:2] - 10'(`OFS_INJ_RESULT0 >> 2))];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // bus strobes: the answer is staged one cycle ahead so every bus output is a flop
    always_comb begin
        setup    = psel & ~penable & ~q.pready;
        acc      = psel & penable & q.pready;
        wr       = acc & pwrite & ~q.pslverr;
        rd       = acc & ~pwrite;
        cfg_wr   = wr && paddr == `OFS_CONFIG;
        reg_sw   = wr && paddr == `OFS_CONTROL && pwdata[`CTRL_REG_START];
        inj_sw   = wr && paddr == `OFS_CONTROL && pwdata[`CTRL_INJ_START];
        reg_stop = wr && paddr == `OFS_CONTROL && pwdata[`CTRL_REG_STOP];
        reg_hw   = trig_rise[0] & q.cfg.reg_hw_trig_enable;
        inj_hw   = trig_rise[1] & q.cfg.inj_hw_trig_enable;
        // a dma transfer counts as a read of the result
        result_read = (rd && paddr == `OFS_RESULT) | dma_ack;
        // one-shot end keeps the result register as it stands
        freeze    = dma_frozen;
        reg_block = q.cfg.auto_delay_enable
                    & (q.reg_wait | (q.cfg.auto_injection_enable & q.inj_wait));
    end

    always_comb begin
        n           = q;
        n.cmd.start = 1'b0;
        n.cmd.abort = 1'b0;
        n.pready    = 1'b0;
        n.pslverr   = 1'b0;
        keep        = 1'b0;
        dma_issue   = 1'b0;
        inj_start   = 1'b0;
        reg_start   = 1'b0;

        if (setup) begin
            n.pready  = 1'b1;
            n.prdata  = rd_word;
            n.pslverr = ~hit;
        end

        // software side first, hardware events below may override
        if (wr && paddr == `OFS_STATUS) begin
            if (pwdata[`STAT_CONV_DONE]) begin
                n.conv_done = 1'b0;
                n.reg_wait  = 1'b0;
            end
            if (pwdata[`STAT_OVERRUN]) begin
                n.overrun_flag = 1'b0;
            end
            if (pwdata[`STAT_INJ_DONE]) begin
                n.injected_sequence_done_flag = 1'b0;
                n.inj_wait                    = 1'b0;
            end
        end
        if (wr && paddr == `OFS_IRQ_EN) begin
            n.overrun_irq_enable = pwdata[`IRQEN_OVERRUN];
        end
        if (cfg_wr) begin
            n.cfg = config_t'(pwdata[`CONFIG_W-1:0]);
        end
        if (result_read) begin
            n.conv_done = 1'b0;
            n.reg_wait  = 1'b0;
        end

        // regular triggers
        if (reg_sw) begin
            n.reg_run  = 1'b1;
            n.reg_wait = 1'b0;
            n.reg_pend = 1'b0;
        end else if (reg_hw) begin
            if (q.reg_run || q.st == ST_REG || (q.cfg.auto_delay_enable && q.reg_wait)) begin
                n.reg_pend = q.reg_pend;
            end else if (q.cfg.auto_delay_enable && (q.inj_run || q.st == ST_INJ || q.inj_wait)) begin
                n.reg_pend = 1'b1;
            end else begin
                n.reg_run = 1'b1;
            end
        end
        // a held trigger starts once the injected delay has ended
        if (q.reg_pend && !q.inj_run && q.st != ST_INJ && !q.inj_wait) begin
            n.reg_run  = 1'b1;
            n.reg_pend = 1'b0;
        end

        // injected triggers
        if (inj_sw) begin
            n.inj_run  = 1'b1;
            n.inj_wait = 1'b0;
        end else if (inj_hw) begin
            if (!(q.inj_run || q.st == ST_INJ || (q.cfg.auto_delay_enable && q.inj_wait))) begin
                n.inj_run = 1'b1;
            end
        end

        case (q.st)
            ST_IDLE: begin
                if (q.inj_run) begin
                    inj_start = 1'b1;
                end else if (q.reg_run && !reg_block) begin
                    reg_start = 1'b1;
                end
            end
            ST_REG: begin
                if (conv_res.done) begin
                    if (n.conv_done) begin
                        n.overrun_flag = 1'b1;
                    end
                    // mode zero drops every result while the flag stands
                    keep = ~freeze & (q.cfg.overrun_mode_select | ~n.overrun_flag);
                    if (keep) begin
                        n.result = conv_res.data;
                    end
                    n.conv_done = 1'b1;
                    dma_issue   = keep & q.cfg.dma_request_enable & ~n.overrun_flag;
                    n.reg_wait  = q.cfg.auto_delay_enable;
                    if (q.reg_idx == q.cfg.reg_len_m1) begin
                        n.reg_idx = 2'b00;
                        if (!q.cfg.repeat_sequence_enable) begin
                            n.reg_run = 1'b0;
                        end
                        if (q.cfg.auto_injection_enable) begin
                            n.inj_run = 1'b1;
                        end
                    end else begin
                        n.reg_idx = q.reg_idx + 2'b01;
                        if (q.cfg.regular_discontinuous_enable) begin
                            n.reg_run = 1'b0;
                        end
                    end
                    // the converter keeps going after an overrun
                    n.st = ST_IDLE;
                end
            end
            ST_INJ: begin
                if (conv_res.done) begin
                    // each injected slot has its own register, so no overrun check here
                    n.inj_result[q.inj_idx] = conv_res.data;
                    if (q.inj_idx == q.cfg.inj_len_m1) begin
                        n.inj_idx                     = 2'b00;
                        n.inj_run                     = 1'b0;
                        n.injected_sequence_done_flag = 1'b1;
                        n.inj_wait                    = q.cfg.auto_delay_enable;
                    end else begin
                        n.inj_idx = q.inj_idx + 2'b01;
                        if (q.cfg.injected_discontinuous_enable) begin
                            n.inj_run = 1'b0;
                        end
                    end
                    n.st = ST_IDLE;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        if (inj_start) begin
            n.cmd.start = 1'b1;
            n.cmd.inj   = 1'b1;
            n.cmd.chan  = q.inj_idx;
            n.st        = ST_INJ;
        end
        if (reg_start) begin
            n.cmd.start = 1'b1;
            n.cmd.inj   = 1'b0;
            n.cmd.chan  = q.reg_idx;
            n.st        = ST_REG;
        end

        // stop request and one-shot end both reset the regular sequence
        if (reg_stop || dma_stop) begin
            n.reg_run  = 1'b0;
            n.reg_pend = 1'b0;
            n.reg_idx  = 2'b00;
            if (q.st == ST_REG) begin
                n.cmd.abort = 1'b1;
                n.cmd.start = 1'b0;
                n.st        = ST_IDLE;
            end
        end
        if (dma_stop && q.st == ST_INJ) begin
            n.cmd.abort = 1'b1;
            n.inj_run   = 1'b0;
            n.inj_idx   = 2'b00;
            n.st        = ST_IDLE;
        end

        n.irq = n.overrun_flag & n.overrun_irq_enable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q                    <= '0;
            q.st                 <= ST_IDLE;
            q.cfg                <= `CONFIG_RESET;
            q.overrun_irq_enable <= `IRQEN_RESET;
        end else begin
            q <= n;
        end
    end

    assign pready      = q.pready;
    assign prdata      = q.prdata;
    assign pslverr     = q.pslverr;
    assign conv_cmd    = q.cmd;
    assign overrun_irq = q.irq;
endmodule

// [design/adc_ctl_cfg.svh]
// register map, field positions and reset values of the converter control block
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

`define OFS_STATUS       12'h000
`define OFS_IRQ_EN       12'h004
`define OFS_CONTROL      12'h008
`define OFS_CONFIG       12'h00c
`define OFS_RESULT       12'h010
`define OFS_INJ_RESULT0  12'h014
`define OFS_INJ_RESULT3  12'h020

`define STAT_CONV_DONE   0
`define STAT_OVERRUN     1
`define STAT_INJ_DONE    2
`define STAT_REG_BUSY    3
`define STAT_INJ_BUSY    4
`define STAT_REG_WAIT    5
`define STAT_INJ_WAIT    6
`define STAT_DMA_FROZEN  7

`define IRQEN_OVERRUN    1

`define CTRL_REG_START   0
`define CTRL_INJ_START   1
`define CTRL_REG_STOP    2

`define CONFIG_W         14
`define CONFIG_RESET     14'h0000
`define IRQEN_RESET      1'b0
`define RESULT_W         12
`define SYNC_STAGES      3

`endif

// [design/adc_ctl_pkg.sv]
// types shared by the converter control block
`include "adc_ctl_cfg.svh"
package adc_ctl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REG  = 3'b010,
        ST_INJ  = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic [1:0] inj_len_m1;
        logic [1:0] reg_len_m1;
        logic       inj_hw_trig_enable;
        logic       reg_hw_trig_enable;
        logic       injected_discontinuous_enable;
        logic       regular_discontinuous_enable;
        logic       repeat_sequence_enable;
        logic       auto_injection_enable;
        logic       auto_delay_enable;
        logic       overrun_mode_select;
        logic       dma_circular_select;
        logic       dma_request_enable;
    } config_t;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       inj;
        logic [1:0] chan;
    } conv_cmd_t;

    typedef struct packed {
        logic                 done;
        logic [`RESULT_W-1:0] data;
    } conv_res_t;

    typedef struct packed {
        seq_state_t                st;
        config_t                   cfg;
        logic                      overrun_irq_enable;
        logic                      conv_done;
        logic                      overrun_flag;
        logic                      injected_sequence_done_flag;
        logic                      reg_run;
        logic                      reg_pend;
        logic                      reg_wait;
        logic                      inj_run;
        logic                      inj_wait;
        logic [1:0]                reg_idx;
        logic [1:0]                inj_idx;
        logic [`RESULT_W-1:0]      result;
        logic [3:0][`RESULT_W-1:0] inj_result;
        conv_cmd_t                 cmd;
        logic                      irq;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
    } ctl_state_t;

endpackage

// [design/dma_req_ctl.sv]
// dma request handshake with one-shot end detection
`timescale 1ns/100ps
module dma_req_ctl (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // from the sequencer
    input  wire logic issue,
    input  wire logic enable,
    input  wire logic circular,
    input  wire logic clear,
    // dma controller side
    input  wire logic dma_ack,
    input  wire logic dma_transfer_complete,
    output logic      dma_req,
    // state back to the sequencer
    output logic      frozen,
    output logic      stop
);
    typedef struct packed {
        logic req;
        logic done;
        logic stop;
    } dma_state_t;

    dma_state_t q;
    dma_state_t n;

    always_comb begin
        n      = q;
        n.stop = 1'b0;
        if (dma_ack) begin
            n.req = 1'b0;
        end
        if (issue && !q.done) begin
            n.req = 1'b1;
        end
        if (!enable) begin
            n.req = 1'b0;
        end
        // a config write in the same cycle as the block end loses: the end sticks
        if (clear) begin
            n.done = 1'b0;
        end
        // circular mode ignores the end of the dma block
        if (dma_transfer_complete && enable && !circular && !q.done) begin
            n.done = 1'b1;
            n.stop = 1'b1;
            n.req  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign dma_req = q.req;
    assign frozen  = q.done;
    assign stop    = q.stop;
endmodule

// [design/trig_sync.sv]
// three-stage synchroniser with rising-edge pulse per trigger pin
`timescale 1ns/100ps
module trig_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins and pulses
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
        logic [W-1:0] rise;
    } sync_state_t;

    sync_state_t q;
    sync_state_t n;

    always_comb begin
        n    = q;
        n.s1 = pin;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            // s1 feeds only s2; a change counts once s2 and s3 agree
            n.rise[i] = 1'b0;
            if (q.s2[i] == q.s3[i]) begin
                n.level[i] = q.s3[i];
                n.rise[i]  = q.s3[i] & ~q.level[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rise = q.rise;
endmodule

// [tb/adc_ctl_properties.sv]
// port-level properties of the converter control block
`timescale 1ns/100ps
module adc_ctl_properties (
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // core, dma and interrupt
    input wire adc_ctl_pkg::conv_cmd_t conv_cmd,
    input wire adc_ctl_pkg::conv_res_t conv_res,
    input wire logic                   dma_req,
    input wire logic                   dma_ack,
    input wire logic                   dma_transfer_complete,
    input wire logic                   overrun_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_req_after_done: assert property ($rose(dma_req) |-> $past(conv_res.done))
        else $error("dma request without a fresh result");
    a_ack_clears_req: assert property (dma_req && dma_ack |=> !dma_req)
        else $error("dma request survived its acknowledge");
    a_req_waits_ack: assert property (dma_req && !dma_ack && !dma_transfer_complete && !conv_res.done && !psel
        |=> dma_req)
        else $error("dma request dropped without acknowledge");
    a_irq_held: assert property (overrun_irq && !(psel && pwrite) |=> overrun_irq)
        else $error("overrun interrupt dropped without a write");
    a_irq_cause: assert property ($rose(overrun_irq) |-> $past(conv_res.done) || $past(conv_res.done, 2)
        || $past(psel && pwrite) || $past(psel && pwrite, 2))
        else $error("overrun interrupt rose without a completion");
    a_start_single: assert property (conv_cmd.start |=> !conv_cmd.start)
        else $error("start pulse longer than one cycle");
    a_rest_after_done: assert property (conv_res.done |=> !conv_cmd.start)
        else $error("start right after completion");
    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind adc_ctl adc_ctl_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .conv_cmd(conv_cmd), .conv_res(conv_res), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_transfer_complete(dma_transfer_complete), .overrun_irq(overrun_irq));

// [tb/adc_overrun_dma_autodelay_tb_top.sv]
// self-checking testbench of the converter control block
`timescale 1ns/100ps
module adc_overrun_dma_autodelay_tb_top;
    import adc_ctl_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic        pready, pslverr, err, dma_req, dma_ack, eot, overrun_irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, v;
    logic [11:0] dat [0:255];
    logic [7:0]  blen = 0;
    logic [1:0]  trig = 0;
    conv_cmd_t   conv_cmd;
    conv_res_t   conv_res = 0;
    int seed = 8778, miscompares = 0, tests_run = 0, ndone = 0, nstart = 0, nack = 0, lat = 0, i, j, k, m;
    always #50 pclk = ~pclk;
    adc_ctl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .hw_trig(trig), .conv_cmd(conv_cmd), .conv_res(conv_res), .dma_req(dma_req),
        .dma_ack(dma_ack), .dma_transfer_complete(eot), .overrun_irq(overrun_irq));
    dma_model u_dma (.pclk(pclk), .presetn(presetn), .slow(slow), .block_len(blen),
        .dma_req(dma_req), .dma_ack(dma_ack), .dma_transfer_complete(eot));
    // analog core stand-in: random latency and random data
    always @(posedge pclk) begin
        conv_res.done <= 1'b0;
        if (dma_ack) nack <= nack + 1;
        if (conv_cmd.start) begin
            lat <= 2 + ($unsigned($random(seed)) % 4);
            nstart <= nstart + 1;
        end else if (conv_cmd.abort) lat <= 0;
        else if (lat > 0) lat <= lat - 1;
        if (lat == 1 && !conv_cmd.abort) begin
            v = $random(seed);
            conv_res <= {1'b1, v[11:0]};
            dat[ndone[7:0]] <= v[11:0];
            ndone <= ndone + 1;
        end
    end
    task automatic complete_run();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin miscompares++; complete_run(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_done(input int n);
        int c;
        for (c = 0; c < 200 && ndone < n; c++) @(posedge pclk);
        if (ndone < n) begin miscompares++; complete_run(); end
        repeat (3) @(posedge pclk);
    endtask
    task automatic convert();
        int n0;
        n0 = ndone;
        apb(1, 12'h008, 32'h1);
        wait_done(n0 + 1);
    endtask
    task automatic pulse(input logic [1:0] t);
        trig <= t;
        repeat (4) @(posedge pclk);
        trig <= 2'b00;
        repeat (60) @(posedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h00c, 0); check("config reset", rd, 0);
        apb(0, 12'h004, 0); check("irq enable reset", rd, 0);
        apb(0, 12'h040, 0); check("unmapped error", {rd[30:0], err}, 1);
        apb(1, 12'h004, 32'h2);
        for (m = 0; m < 2; m++) begin
            apb(1, 12'h00c, m << 2);
            for (i = 0; i < 3; i++) convert();
            apb(0, 12'h000, 0); check("overrun status", rd[1:0], 2'b11);
            check("overrun irq", overrun_irq, 1);
            apb(0, 12'h010, 0); check("result", rd, m ? dat[ndone - 1] : dat[ndone - 3]);
            apb(0, 12'h000, 0); check("overrun sticky", rd[1], 1);
            apb(1, 12'h000, 32'h3);
            apb(0, 12'h000, 0); check("overrun cleared", rd[1:0], 0);
            check("irq cleared", overrun_irq, 0);
        end
        // block of two transfers: one-shot freezes after it, circular runs on
        for (m = 0; m < 2; m++) begin
            blen <= 8'h02; slow <= m[0]; k = nack;
            apb(1, 12'h00c, 1 | (m << 1));
            for (i = 0; i < 3; i++) begin convert(); repeat (12) @(posedge pclk); end
            check("dma acks", nack - k, m ? 3 : 2);
            check("dma idle", dma_req, 0);
            apb(0, 12'h000, 0); check("frozen", rd[7], !m);
            apb(0, 12'h010, 0); check("frozen result", rd, m ? dat[ndone - 1] : dat[ndone - 2]);
        end
        apb(1, 12'h00c, 32'h28);
        k = nstart;
        apb(1, 12'h008, 32'h1);
        pulse(0);
        check("held by delay", nstart - k, 1);
        apb(0, 12'h010, 0);
        pulse(0);
        check("released by read", nstart - k, 2);
        apb(0, 12'h000, 0); check("no overrun", rd[1], 0);
        apb(1, 12'h008, 32'h4);
        j = nstart;
        apb(0, 12'h010, 0);
        pulse(0);
        check("stopped", nstart - j, 0);
        apb(1, 12'h00c, 32'h308);
        k = nstart;
        pulse(2'b01);
        pulse(2'b11);
        pulse(2'b10);
        check("hw in delay", nstart - k, 2);
        // auto-injection loop
        apb(1, 12'h000, 32'h5);
        apb(1, 12'h00c, 32'h38);
        apb(1, 12'h008, 32'h1);
        pulse(0);
        apb(0, 12'h010, 0);
        pulse(0);
        check("injected delay", nstart - k, 4);
        apb(1, 12'h000, 32'h4);
        pulse(0);
        check("cleared", nstart - k, 6);
        apb(1, 12'h000, 32'h4);
        apb(1, 12'h008, 32'h4);
        apb(0, 12'h010, 0);
        pulse(0);
        check("loop stopped", nstart - k, 6);
        complete_run();
    end
endmodule

// [tb/dma_model.sv]
// dma controller model: acks requests, flags block end
`timescale 1ns/100ps
module dma_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       slow,
    input  wire logic [7:0] block_len,
    // request side
    input  wire logic       dma_req,
    output logic            dma_ack,
    output logic            dma_transfer_complete
);
    logic [3:0] wait_q;
    logic [7:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ack <= 1'b0;
            dma_transfer_complete <= 1'b0;
            wait_q <= 4'h0;
            cnt_q <= 8'h00;
        end else begin
            dma_ack <= 1'b0;
            dma_transfer_complete <= 1'b0;
            if (dma_req && !dma_ack) begin
                if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
                else begin
                    dma_ack <= 1'b1;
                    wait_q <= slow ? 4'h6 : 4'h0;
                    cnt_q <= (cnt_q + 8'h01 == block_len) ? 8'h00 : cnt_q + 8'h01;
                    // block end pulses with the last ack, as a real controller does
                    dma_transfer_complete <= (cnt_q + 8'h01 == block_len);
                end
            end
        end
    end
endmodule
